/* File: design/kmc_consts.svh */
// Constants for the keypad menu and indicator controller.
// Assumes inclusion wherever key indices or segment codes are needed.
`ifndef KMC_CONSTS_SVH
`define KMC_CONSTS_SVH
`define KMC_CLK_HZ 40000000
`define KMC_DEBOUNCE_US 5000
`define KMC_DEBOUNCE_CYC ((`KMC_CLK_HZ / 1000000) * `KMC_DEBOUNCE_US)
`define KMC_BLINK_MS 250
`define KMC_BLINK_CYC ((`KMC_CLK_HZ / 1000) * `KMC_BLINK_MS)
`define KMC_SCAN_US 1000
`define KMC_SCAN_CYC ((`KMC_CLK_HZ / 1000000) * `KMC_SCAN_US)
`define KMC_KEY_PROG 0
`define KMC_KEY_ENTER 1
`define KMC_KEY_SHIFT 2
`define KMC_KEY_ENC_A 8
`define KMC_KEY_ENC_B 9
`define KMC_GROUP_MAX 4'hF
`define KMC_SEG_DASH 7'h40
`define KMC_SEG_P 7'h73
`define KMC_SEG_E 7'h79
`define KMC_SEG_A 7'h77
`define KMC_SEG_BLANK 7'h00
`define KMC_MON_MAX 3'h7
`endif

/* File: design/kmc_pkg.sv */
// Types shared by the keypad menu and indicator controller.
// Assumes the constants header sits beside it.
package kmc_pkg;
	typedef enum logic [2:0] {
		KMC_MONITOR,
		KMC_GROUP,
		KMC_CODE,
		KMC_VALUE,
		KMC_ALERT
	} kmc_state_t;

	// Drive state presented to the panel.
	typedef struct packed {
		logic running;
		logic forward;
		logic reverse;
		logic remote;
		logic fault;
		logic warning;
		logic keypad_set_en;
		logic [7:0] fault_code;
		logic [7:0] warn_code;
	} kmc_drive_t;

	// Five status lamps.
	typedef struct packed {
		logic run_lamp;
		logic forward_lamp;
		logic reverse_lamp;
		logic remote_lamp;
		logic fault_lamp;
	} kmc_lamps_t;

	// Parameter write to the drive.
	typedef struct packed {
		logic valid;
		logic [3:0] group;
		logic [7:0] code;
		logic [15:0] value;
	} kmc_param_t;
endpackage

/* File: design/kmc_panel.sv */
// Front-panel controller: keys, encoder, menu, display and lamps.
// Assumes key and encoder levels are synchronous to ref_clk, high = pressed.
//
// Contract
// [R1] Run lamp lit while drive runs.
// [R2] Forward and reverse lamps follow rotation.
// [R3] Remote lamp lit when not keypad controlled.
// [R4] Fault lamp lit while fault present.
// [R5] Monitor shows fault code, else warning code.
// [R6] Monitor otherwise shows selected quantity.
// [R7] Four seven-segment digits drive all views.
// [R8] Programming menu: group, code, value levels.
// [R9] Group level shows dash-framed P0 to PF.
// [R10] Eight keys plus encoder are decoded.
// [R11] Program key in monitor enters group level.
// [R12] Enter steps one level deeper.
// [R13] Program key steps one level up.
// [R14] Program key toggles alert and group views.
// [R15] Enter at value level stores parameter.
// [R16] Clockwise step increments selected item.
// [R17] Digit under edit blinks.
// [R18] Monitor clockwise raises setpoint when enabled.
// [R19] Counter-clockwise step decrements selected item.
// [R20] Shift picks edit digit or monitor quantity.
// [R21] Inputs debounced, one action per press.
`timescale 1ns/10ps
`include "kmc_consts.svh"
module kmc_panel #(
	parameter int DEBOUNCE_CYC = `KMC_DEBOUNCE_CYC,
	parameter int BLINK_CYC = `KMC_BLINK_CYC,
	parameter int SCAN_CYC = `KMC_SCAN_CYC
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Operator inputs: eight keys, encoder phases A and B.
	input wire logic [7:0] key_in,
	input wire logic [1:0] enc_in,
	// Drive state and parameter data.
	input wire kmc_pkg::kmc_drive_t drive,
	input wire logic [15:0] param_rd_value,
	input wire logic [15:0] monitor_value,
	// Drive commands.
	output kmc_pkg::kmc_param_t param_wr,
	output logic setpoint_up,
	output logic setpoint_down,
	output logic [2:0] monitor_sel,
	output logic [7:0] other_keys,
	// Display and lamps.
	output logic [6:0] seg,
	output logic [3:0] digit_en,
	output kmc_pkg::kmc_lamps_t lamps
);
	import kmc_pkg::*;

	localparam int NIN = 10;

	logic [NIN-1:0] raw;
	logic [NIN-1:0] stable_reg;
	logic [NIN-1:0] stable_d_reg;
	logic [NIN-1:0] press;
	kmc_state_t state_reg;
	logic [3:0] group_reg;
	logic [7:0] code_reg;
	logic [15:0] value_reg;
	logic [1:0] digit_sel_reg;
	logic [2:0] monitor_reg;
	logic [31:0] blink_cnt_reg;
	logic blink_reg;
	logic [31:0] scan_cnt_reg;
	logic [1:0] scan_reg;
	logic key_prog, key_enter, key_shift, step_cw, step_ccw;
	logic [15:0] digit_step;
	logic [15:0] shown;
	logic [6:0] seg_next;
	logic blank_now;
	logic alert;

	assign raw = {enc_in, key_in};
	assign alert = drive.fault | drive.warning;

	////////////////////////////////////////////////////////////////////////
	// Debounce: one counter per input, level accepted after steady time.
	generate
		for (genvar i = 0; i < NIN; i++) begin : g_deb
			logic [31:0] cnt_reg;
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					cnt_reg <= 32'h0;
					stable_reg[i] <= 1'b0;
				end else if (raw[i] == stable_reg[i]) begin
					cnt_reg <= 32'h0;
				end else if (cnt_reg >= 32'(DEBOUNCE_CYC - 1)) begin
					cnt_reg <= 32'h0;
					stable_reg[i] <= raw[i]; // [R21]
				end else begin
					cnt_reg <= cnt_reg + 32'h1;
				end
			end
		end
	endgenerate

	// Delayed copy for edge detection.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stable_d_reg <= '0;
		end else begin
			stable_d_reg <= stable_reg;
		end
	end

	// One pulse per press; encoder detent on rising edge of phase A.
	assign press = stable_reg & ~stable_d_reg; // [R21]
	assign key_prog = press[`KMC_KEY_PROG]; // [R10]
	assign key_enter = press[`KMC_KEY_ENTER]; // [R10]
	assign key_shift = press[`KMC_KEY_SHIFT]; // [R10]
	assign step_cw = press[`KMC_KEY_ENC_A] & ~stable_reg[`KMC_KEY_ENC_B];
	assign step_ccw = press[`KMC_KEY_ENC_A] & stable_reg[`KMC_KEY_ENC_B];

	// The remaining five keys are handed on as press pulses.
	assign other_keys = {press[7:3], 3'h0}; // [R10]

	// Weight of the digit under edit.
	always_comb begin
		case (digit_sel_reg)
			2'h0: digit_step = 16'h0001;
			2'h1: digit_step = 16'h0010;
			2'h2: digit_step = 16'h0100;
			default: digit_step = 16'h1000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Menu state machine.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= KMC_MONITOR;
		end else begin
			case (state_reg) // [R8]
				KMC_MONITOR: begin
					if (alert) begin
						state_reg <= KMC_ALERT; // [R5]
					end else if (key_prog) begin
						state_reg <= KMC_GROUP; // [R11]
					end
				end
				KMC_ALERT: begin
					if (!alert) begin
						state_reg <= KMC_MONITOR;
					end else if (key_prog) begin
						state_reg <= KMC_GROUP; // [R14]
					end
				end
				KMC_GROUP: begin
					if (key_prog) begin
						// [R13] [R14]
						state_reg <= alert ? KMC_ALERT : KMC_MONITOR;
					end else if (key_enter) begin
						state_reg <= KMC_CODE; // [R12]
					end
				end
				KMC_CODE: begin
					if (key_prog) begin
						state_reg <= KMC_GROUP; // [R13]
					end else if (key_enter) begin
						state_reg <= KMC_VALUE; // [R12]
					end
				end
				KMC_VALUE: begin
					if (key_prog || key_enter) begin
						state_reg <= KMC_CODE; // [R13]
					end
				end
				default: state_reg <= KMC_MONITOR;
			endcase
		end
	end

	// Group and code selection by encoder steps.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			group_reg <= 4'h0;
			code_reg <= 8'h00;
		end else if (state_reg == KMC_GROUP) begin
			code_reg <= 8'h00;
			if (step_cw) begin
				group_reg <= group_reg + 4'h1; // [R16]
			end else if (step_ccw) begin
				group_reg <= group_reg - 4'h1; // [R19]
			end
		end else if (state_reg == KMC_CODE) begin
			if (step_cw) begin
				code_reg <= code_reg + 8'h01; // [R16]
			end else if (step_ccw) begin
				code_reg <= code_reg - 8'h01; // [R19]
			end
		end
	end

	// Value edit: loaded on entry, stepped at the selected digit.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			value_reg <= 16'h0000;
			digit_sel_reg <= 2'h0;
		end else if (state_reg == KMC_CODE && key_enter) begin
			value_reg <= param_rd_value;
			digit_sel_reg <= 2'h0;
		end else if (state_reg == KMC_VALUE) begin
			if (step_cw) begin
				value_reg <= value_reg + digit_step; // [R16]
			end else if (step_ccw) begin
				value_reg <= value_reg - digit_step; // [R19]
			end
			if (key_shift) begin
				digit_sel_reg <= digit_sel_reg + 2'h1; // [R20]
			end
		end
	end

	// Parameter store pulse on enter at value level.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			param_wr <= '0;
		end else begin
			param_wr.valid <= (state_reg == KMC_VALUE) && key_enter; // [R15]
			param_wr.group <= group_reg;
			param_wr.code <= code_reg;
			param_wr.value <= value_reg;
		end
	end

	// Monitor quantity select and setpoint stepping.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			monitor_reg <= 3'h0;
			setpoint_up <= 1'b0;
			setpoint_down <= 1'b0;
		end else begin
			if (state_reg == KMC_MONITOR && key_shift) begin
				// [R20]
				monitor_reg <= (monitor_reg == `KMC_MON_MAX) ? 3'h0 :
					monitor_reg + 3'h1;
			end
			setpoint_up <= (state_reg == KMC_MONITOR) && drive.keypad_set_en
				&& step_cw; // [R18]
			setpoint_down <= (state_reg == KMC_MONITOR) &&
				drive.keypad_set_en && step_ccw; // [R18]
		end
	end
	assign monitor_sel = monitor_reg; // [R6]

	////////////////////////////////////////////////////////////////////////
	// Blink and digit scan timers.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= 1'b0;
		end else if (blink_cnt_reg >= 32'(BLINK_CYC - 1)) begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= ~blink_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 32'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			scan_cnt_reg <= 32'h0;
			scan_reg <= 2'h0;
		end else if (scan_cnt_reg >= 32'(SCAN_CYC - 1)) begin
			scan_cnt_reg <= 32'h0;
			scan_reg <= scan_reg + 2'h1; // [R7]
		end else begin
			scan_cnt_reg <= scan_cnt_reg + 32'h1;
		end
	end

	// Hex to segments, bit 0 = segment a.
	function automatic logic [6:0] hex_seg(input logic [3:0] h);
		case (h)
			4'h0: hex_seg = 7'h3F;
			4'h1: hex_seg = 7'h06;
			4'h2: hex_seg = 7'h5B;
			4'h3: hex_seg = 7'h4F;
			4'h4: hex_seg = 7'h66;
			4'h5: hex_seg = 7'h6D;
			4'h6: hex_seg = 7'h7D;
			4'h7: hex_seg = 7'h07;
			4'h8: hex_seg = 7'h7F;
			4'h9: hex_seg = 7'h6F;
			4'hA: hex_seg = 7'h77;
			4'hB: hex_seg = 7'h7C;
			4'hC: hex_seg = 7'h39;
			4'hD: hex_seg = 7'h5E;
			4'hE: hex_seg = 7'h79;
			default: hex_seg = 7'h71;
		endcase
	endfunction

	// Segment pattern for the digit being scanned.
	always_comb begin
		shown = 16'h0000;
		seg_next = `KMC_SEG_BLANK;
		blank_now = 1'b0;
		case (state_reg)
			KMC_GROUP: begin
				// [R9]
				case (scan_reg)
					2'h3: seg_next = `KMC_SEG_DASH;
					2'h2: seg_next = `KMC_SEG_P;
					2'h1: seg_next = hex_seg(group_reg);
					default: seg_next = `KMC_SEG_DASH;
				endcase
			end
			KMC_ALERT: begin
				// [R5]
				shown = drive.fault ? {8'h00, drive.fault_code} :
					{8'h00, drive.warn_code};
				if (scan_reg == 2'h3) begin
					seg_next = drive.fault ? `KMC_SEG_E : `KMC_SEG_A;
				end else if (scan_reg == 2'h2) begin
					seg_next = `KMC_SEG_BLANK;
				end else begin
					seg_next = hex_seg(shown[scan_reg*4 +: 4]);
				end
			end
			KMC_CODE: begin
				shown = {4'h0, group_reg, code_reg};
				seg_next = hex_seg(shown[scan_reg*4 +: 4]);
			end
			KMC_VALUE: begin
				shown = value_reg;
				blank_now = (scan_reg == digit_sel_reg) && blink_reg; // [R17]
				seg_next = blank_now ? `KMC_SEG_BLANK :
					hex_seg(shown[scan_reg*4 +: 4]);
			end
			default: begin
				shown = monitor_value; // [R6]
				seg_next = hex_seg(shown[scan_reg*4 +: 4]);
			end
		endcase
	end

	// Registered display drive, one digit at a time.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			seg <= `KMC_SEG_BLANK;
			digit_en <= 4'h0;
		end else begin
			seg <= seg_next; // [R7]
			digit_en <= 4'h1 << scan_reg; // [R7]
		end
	end

	// Status lamps follow the drive state.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lamps <= '0;
		end else begin
			lamps.run_lamp <= drive.running; // [R1]
			lamps.forward_lamp <= drive.running & drive.forward; // [R2]
			lamps.reverse_lamp <= drive.running & drive.reverse; // [R2]
			lamps.remote_lamp <= drive.remote; // [R3]
			lamps.fault_lamp <= drive.fault; // [R4]
		end
	end
endmodule

/* File: test/kmc_panel_sva.sv */
// Checker for the panel controller, bound to its ports.
// Assumes one clock domain with reset_n asynchronous and active low.
`timescale 1ns/10ps
module kmc_panel_chk
	import kmc_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// Watched inputs.
	input wire logic [7:0] key_in,
	input wire kmc_pkg::kmc_drive_t drive,
	// Watched outputs.
	input wire kmc_pkg::kmc_param_t param_wr,
	input wire logic setpoint_up,
	input wire logic setpoint_down,
	input wire logic [7:0] other_keys,
	input wire logic [3:0] digit_en,
	input wire kmc_pkg::kmc_lamps_t lamps
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////
	// A pulse that drops after exactly one cycle.
	sequence s_drop(sig);
		sig ##1 !sig;
	endsequence
	property p_run;
		$past(reset_n) |-> lamps.run_lamp == $past(drive.running);
	endproperty
	a_run: assert property (p_run) else $error("run lamp wrong");
	property p_forward;
		$past(reset_n) |->
			lamps.forward_lamp == ($past(drive.running) && $past(drive.forward));
	endproperty
	a_forward: assert property (p_forward)
		else $error("forward lamp wrong");
	property p_reverse;
		$past(reset_n) |->
			lamps.reverse_lamp == ($past(drive.running) && $past(drive.reverse));
	endproperty
	a_reverse: assert property (p_reverse)
		else $error("reverse lamp wrong");
	property p_rmt;
		$past(reset_n) |-> lamps.remote_lamp == $past(drive.remote);
	endproperty
	a_rmt: assert property (p_rmt) else $error("remote lamp wrong");
	property p_flt;
		$past(reset_n) |-> lamps.fault_lamp == $past(drive.fault);
	endproperty
	a_flt: assert property (p_flt) else $error("fault lamp wrong");
	property p_scan;
		$past(reset_n) |-> $onehot(digit_en);
	endproperty
	a_scan: assert property (p_scan) else $error("digit scan wrong");
	property p_wr;
		param_wr.valid |-> s_drop(param_wr.valid);
	endproperty
	a_wr: assert property (p_wr) else $error("store pulse long");
	property p_sp;
		setpoint_up |-> s_drop(setpoint_up) and !setpoint_down;
	endproperty
	a_sp: assert property (p_sp) else $error("setpoint pulse wrong");
	property p_oth_src;
		other_keys != 8'h00 |-> (other_keys & ~key_in) == 8'h00;
	endproperty
	a_oth_src: assert property (p_oth_src) else $error("key pulse");
	// A key press pulse never stands for two cycles running.
	property p_oth_once;
		(other_keys & $past(other_keys)) == 8'h00;
	endproperty
	a_oth_once: assert property (p_oth_once)
		else $error("key pulse long");
endmodule

bind kmc_panel kmc_panel_chk u_kmc_panel_chk (.ref_clk, .reset_n,
	.key_in, .drive, .param_wr, .setpoint_up, .setpoint_down,
	.other_keys, .digit_en, .lamps);

/* File: test/kmc_operator.sv */
// Operator model: presses keys and turns the encoder one detent.
// Assumes the filter length of the panel is well under HOLD cycles.
`timescale 1ns/10ps
module kmc_operator #(
	parameter int HOLD = 10
) (
	// Clock.
	ref_clk,
	// Operator controls.
	key_in,
	enc_in
);
	input wire logic ref_clk;
	output logic [7:0] key_in;
	output logic [1:0] enc_in;

	// Nothing pressed at start.
	initial begin
		key_in = 8'h00;
		enc_in = 2'h0;
	end

	// Holds a key past the filter, then lets it settle released.
	task automatic press(input int k);
		@(posedge ref_clk);
		#1;
		key_in[k] = 1'b1;
		repeat (HOLD) @(posedge ref_clk);
		#1;
		key_in[k] = 1'b0;
		repeat (HOLD) @(posedge ref_clk);
		#1;
	endtask

	// One detent: phase B sets the direction before phase A rises.
	task automatic step(input logic cw);
		@(posedge ref_clk);
		#1;
		enc_in[1] = ~cw;
		repeat (HOLD) @(posedge ref_clk);
		#1;
		enc_in[0] = 1'b1;
		repeat (HOLD) @(posedge ref_clk);
		#1;
		enc_in = 2'h0;
		repeat (HOLD) @(posedge ref_clk);
		#1;
	endtask
endmodule

/* File: test/tb_kmc_panel.sv */
// Self-checking bench for the panel controller.
// Assumes short filter, blink and scan counts set below.
`timescale 1ns/10ps
`include "kmc_consts.svh"
module tb_kmc_panel;
	import kmc_pkg::*;
	logic ref_clk, reset_n;
	logic [7:0] key_in, other_keys, oth_q;
	logic [1:0] enc_in;
	kmc_drive_t drive;
	logic [15:0] param_rd_value, monitor_value, rv;
	kmc_param_t param_wr, wr_q;
	logic setpoint_up, setpoint_down;
	logic [2:0] monitor_sel;
	logic [6:0] seg;
	logic [3:0] digit_en;
	kmc_lamps_t lamps;
	logic [31:0] r;
	int error_cnt, checks, up_n, dn_n, wr_n;
	int seed = 32'h58909c3d;

	kmc_panel #(.DEBOUNCE_CYC(4), .BLINK_CYC(8), .SCAN_CYC(2)) u_kmc_panel (
		.ref_clk, .reset_n, .key_in, .enc_in, .drive, .param_rd_value,
		.monitor_value, .param_wr, .setpoint_up, .setpoint_down,
		.monitor_sel, .other_keys, .seg, .digit_en, .lamps);
	kmc_operator u_kmc_operator (.ref_clk, .key_in, .enc_in);

	// Clock of 25 ns.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Counts pulses and keeps the last stored parameter.
	always @(posedge ref_clk) begin
		if (setpoint_up) up_n++;
		if (setpoint_down) dn_n++;
		if (param_wr.valid) begin
			wr_n++;
			wr_q = param_wr;
		end
		oth_q = oth_q | other_keys;
	end

	function automatic kmc_lamps_t lamp_exp(input kmc_drive_t d);
		return {d.running, d.running & d.forward, d.running & d.reverse,
			d.remote, d.fault};
	endfunction

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (e !== g) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// Waits for a scanned digit, then compares its segments.
	task seg_at(input logic [3:0] d, input logic [6:0] e);
		int i;
		i = 0;
		while (digit_en !== d && i < 40) begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		chk("seg", {9'h000, e}, {9'h000, seg});
	endtask

	// Segment pattern of a hex digit, bit 0 = segment a.
	function automatic logic [6:0] seg_of(input logic [3:0] h);
		logic [111:0] tab;
		tab = {7'h71, 7'h79, 7'h5E, 7'h39, 7'h7C, 7'h77, 7'h6F, 7'h7F,
			7'h07, 7'h7D, 7'h6D, 7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F};
		return tab[h*7 +: 7];
	endfunction

	// Watches digit 1 under edit: it must be seen both blank and lit.
	task blink_chk;
		int i, off_n, on_n;
		off_n = 0;
		on_n = 0;
		for (i = 0; i < 48; i++) begin
			@(posedge ref_clk);
			#1;
			if (digit_en === 4'b0010 && seg === `KMC_SEG_BLANK) off_n++;
			if (digit_en === 4'b0010 && seg !== `KMC_SEG_BLANK) on_n++;
		end
		chk("blink", 16'h0003, {14'h0000, off_n > 0, on_n > 0});
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short.
	initial begin
		repeat (6000) @(posedge ref_clk);
		error_cnt++;
		final_report;
	end

	// Main sequence.
	initial begin
		reset_n = 1'b0;
		drive = '0;
		param_rd_value = 16'h0000;
		monitor_value = 16'h0000;
		oth_q = 8'h00;
		repeat (10) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		repeat (30) begin
			r = $random(seed);
			drive = r[22:0];
			@(posedge ref_clk);
			#1;
			chk("lamps", {11'h000, lamp_exp(drive)}, {11'h000, lamps});
		end
		drive = '0;
		drive.keypad_set_en = 1'b1;
		r = $random(seed);
		monitor_value = r[15:0];
		repeat (4) @(posedge ref_clk);
		#1;
		seg_at(4'b0001, seg_of(r[3:0]));
		seg_at(4'b1000, seg_of(r[15:12]));
		$display("lamps done");
		u_kmc_operator.step(1'b1);
		u_kmc_operator.step(1'b0);
		chk("up", 16'h0001, 16'(up_n));
		chk("down", 16'h0001, 16'(dn_n));
		u_kmc_operator.press(`KMC_KEY_SHIFT);
		chk("msel", 16'h0001, {13'h0000, monitor_sel});
		for (int k = 3; k < 8; k++) u_kmc_operator.press(k);
		chk("other", 16'h00F8, {8'h00, oth_q});
		$display("monitor done");
		r = $random(seed);
		rv = r[15:0] & 16'hCCCC;
		param_rd_value = rv;
		u_kmc_operator.press(`KMC_KEY_PROG);
		seg_at(4'b0100, `KMC_SEG_P);
		seg_at(4'b1000, `KMC_SEG_DASH);
		u_kmc_operator.step(1'b1);
		seg_at(4'b0010, seg_of(4'h1));
		u_kmc_operator.step(1'b0);
		seg_at(4'b0010, seg_of(4'h0));
		u_kmc_operator.step(1'b0);
		seg_at(4'b0010, seg_of(4'hF));
		u_kmc_operator.press(`KMC_KEY_ENTER);
		u_kmc_operator.step(1'b1);
		seg_at(4'b0001, seg_of(4'h1));
		seg_at(4'b0100, seg_of(4'hF));
		u_kmc_operator.press(`KMC_KEY_ENTER);
		u_kmc_operator.step(1'b1);
		u_kmc_operator.press(`KMC_KEY_SHIFT);
		u_kmc_operator.step(1'b1);
		u_kmc_operator.step(1'b1);
		u_kmc_operator.step(1'b0);
		blink_chk;
		seg_at(4'b0001, seg_of(rv[3:0] + 4'h1));
		u_kmc_operator.press(`KMC_KEY_ENTER);
		chk("wr_n", 16'h0001, 16'(wr_n));
		chk("group", 16'h000F, {12'h000, wr_q.group});
		chk("code", 16'h0001, {8'h00, wr_q.code});
		chk("value", rv + 16'h0011, wr_q.value);
		u_kmc_operator.press(`KMC_KEY_PROG);
		u_kmc_operator.press(`KMC_KEY_PROG);
		u_kmc_operator.step(1'b1);
		chk("up2", 16'h0002, 16'(up_n));
		$display("menu done");
		drive.fault = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		seg_at(4'b1000, `KMC_SEG_E);
		u_kmc_operator.press(`KMC_KEY_PROG);
		seg_at(4'b0100, `KMC_SEG_P);
		u_kmc_operator.press(`KMC_KEY_PROG);
		seg_at(4'b1000, `KMC_SEG_E);
		r = $random(seed);
		drive.fault = 1'b0;
		drive.warning = 1'b1;
		drive.warn_code = r[7:0];
		repeat (4) @(posedge ref_clk);
		#1;
		seg_at(4'b1000, `KMC_SEG_A);
		seg_at(4'b0001, seg_of(r[3:0]));
		seg_at(4'b0010, seg_of(r[7:4]));
		u_kmc_operator.press(`KMC_KEY_PROG);
		seg_at(4'b0100, `KMC_SEG_P);
		$display("alert done");
		drive.running = 1'b1;
		reset_n = 1'b0;
		#1;
		chk("rst_lamps", 16'h0000, {11'h000, lamps});
		chk("rst_msel", 16'h0000, {13'h0000, monitor_sel});
		@(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		@(posedge ref_clk);
		#1;
		chk("rst_run", 16'h0001, {15'h0000, lamps.run_lamp});
		seg_at(4'b1000, `KMC_SEG_A);
		$display("reset done");
		final_report;
	end
endmodule
